// [rtl/armature_current_loop_control.sv]
// armature current loop: tapers, slew, PI loop, overload, autotune, standstill
// Function
// R1 - above each taper threshold the current limit falls with speed, slope/128
// R2 - two read-only flags show speed beyond each taper threshold
// R3 - current feedback readable as signed value within plus or minus 1000
// R4 - displayed amps are feedback times scaler, within 1999, no control effect
// R5 - firing angle output 277 to 1023, 1023 fully phased forward
// R6 - demand slew limited to Imax times 6f times setting over 256
// R7 - operator sets scaler to Imax/10 above 1999 A, else Imax
// R8 - overload integrates only when feedback exceeds threshold, default 700
// R9 - accumulator rises with heating time, falls with cooling time
// R10 - operator keeps heating time below cooling time
// R11 - accumulator readable 0 to 1999, trip when it reaches trip point
// R12 - after autotune the ready relay opens 50 ms, then enable clears
// R13 - reduced endstop bit raises the back endstop of the firing angle
// R14 - gains applied as value/512, continuous integral gain as value/1024
// R15 - motor constant scales demand feed-forward; autotune writes it
// R16 - firing inhibit stops both bridges and resets the ramps
// R17 - standstill phases back below 0.8 percent speed, then inhibits
// R18 - standstill mode 0 engages on stop or zero ref, 1 on stop only
// R19 - direct firing takes the angle from the post-ramp reference
// R20 - with lockout, no bridge change while the partner conducts
// R21 - unless disabled, adaptive control uses high gain when discontinuous
// R22 - taper 1 threshold setting 0 to 1000, default 1000
// R23 - overload, flags and slew update once per control tick
`timescale 1ns/10ps
`include "current_loop_defs.svh"
module armature_current_loop_control
    import current_loop_pkg::*;
#(
    parameter int unsigned TICK_CYCLES  = `TICK_CYCLES,
    parameter int unsigned RELAY_CYCLES = `RELAY_CYCLES
)(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [7:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic [31:0]             dat_o,
    output logic                    ack_o,
    input  wire logic signed [11:0] speed_fb_i,
    input  wire logic signed [11:0] current_fb_i,
    input  wire logic signed [11:0] current_demand_i,
    input  wire logic signed [11:0] post_ramp_ref_i,
    input  wire logic               stop_cmd_i,
    input  wire logic               zero_ref_i,
    input  wire logic               start_i,
    input  wire logic               tune_done_i,
    input  wire tune_result_type    tune_result_i,
    input  wire logic               partner_conducting_i,
    output logic [9:0]              firing_angle_o,
    output logic                    fire_enable_o,
    output logic                    bridge_sel_o,
    output logic                    ramp_reset_o,
    output logic                    ready_relay_o,
    output logic                    overload_trip_o
);
    localparam int unsigned SIX_F = 6 * `SUPPLY_HZ;

    cfg_type             cfg;
    ss_state_type        ss_state;
    tune_state_type      tune_state;
    logic [31:0]         tick_cnt;
    logic                tick;
    logic                partner_meta, partner_s;
    logic                flag1, flag2;
    logic [10:0]         acc;
    logic [17:0]         heat_frac, cool_frac;
    logic [31:0]         relay_cnt;
    logic [7:0]          ss_cnt;
    logic                tune_clear;
    logic signed [15:0]  dem_s;
    logic signed [27:0]  integ;
    logic [31:0]         rd_data;

    function automatic logic [10:0] mag(input logic signed [11:0] v);
        mag = v[11] ? 11'(-v) : 11'(v);
    endfunction

    function automatic logic signed [15:0] lim(input logic signed [27:0] v,
        input logic signed [15:0] lo, input logic signed [15:0] hi);
        if (v < 28'(lo))
            lim = lo;
        else if (v > 28'(hi))
            lim = hi;
        else
            lim = 16'(v);
    endfunction

    // bus handshake: one wait state, ack held a single cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i && stb_i && !ack_o;
    end
    wire wr = cyc_i && stb_i && we_i && ack_o && sel_i[0]; // lands where the master sees ack

    // partner conduction comes from another drive, so synchronise it
    always_ff @(posedge clk_i)
    begin
        partner_meta <= partner_conducting_i;
        partner_s    <= partner_meta;
    end

    // control tick, all slow arithmetic runs on it
    always_ff @(posedge clk_i)
    begin
        if (rst_i || tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 32'h0000_0001;
    end
    assign tick = (tick_cnt == TICK_CYCLES - 1); // R23

    // speed taper of the current limit
    wire [10:0]  spd_abs = mag(speed_fb_i);
    wire [10:0]  cur_abs = mag(current_fb_i);
    wire [10:0]  thr1    = {1'b0, cfg.t1_thr}; // R22
    wire [10:0]  thr2    = {1'b0, cfg.t2_thr};
    wire [18:0]  d1      = (spd_abs > thr1) ? 19'(spd_abs - thr1) : '0;
    wire [18:0]  d2      = (spd_abs > thr2) ? 19'(spd_abs - thr2) : '0;
    wire [18:0]  red1    = (d1 * 19'(cfg.t1_slope)) >> 7; // R1
    wire [18:0]  red2    = (d2 * 19'(cfg.t2_slope)) >> 7; // R1
    wire signed [27:0] lt = 28'sd1000 - 28'(red1) - 28'(red2);
    wire signed [15:0] cur_limit = lim(lt, 16'sh0000, 16'sh03E8);
    wire signed [15:0] dem_t = lim(28'(current_demand_i), -cur_limit, cur_limit);

    // slew step per tick; zero setting freezes the demand
    wire [16:0] step_raw = 17'(SIX_F) * 17'(cfg.slew);
    wire signed [15:0] step = 16'(step_raw >> 8); // R6

    // adaptive choice of algorithm
    wire disc = !cfg.adapt_dis && (cur_abs < `DISC_LEVEL); // R21
    wire signed [15:0] err = dem_s - 16'(current_fb_i);
    wire [8:0] gain_i = disc ? {cfg.kid, 1'b0} : {1'b0, cfg.ki}; // R14
    wire signed [27:0] p_full = 28'(err) * $signed({20'h0, cfg.kp});
    wire signed [27:0] inc    = 28'(err) * $signed({19'h0, gain_i});
    wire signed [27:0] ff     = disc ? (28'(dem_s) * $signed({20'h0, cfg.motor_k})) >>> 8
                                     : 28'sh0; // R15
    wire signed [27:0] i_next = integ + inc;
    // signed mid point keeps the shifts arithmetic for a negative integrator
    wire signed [27:0] raw    = $signed(28'(`ANGLE_MID)) + (integ >>> 10) + (p_full >>> 9) + ff;
    wire signed [15:0] a_min  = cfg.endstop_red ? `ANGLE_MIN_RED : `ANGLE_MIN; // R13
    wire signed [15:0] loop_angle   = lim(raw, a_min, `ANGLE_MAX); // R5
    wire signed [15:0] direct_angle = lim(28'(post_ramp_ref_i), a_min, `ANGLE_MAX);

    // slewed demand and integrator; inhibit and standstill clear them
    always_ff @(posedge clk_i)
    begin
        if (rst_i || cfg.inhibit || ss_state != SS_RUN)
        begin
            dem_s <= '0; // R16
            integ <= '0;
        end
        else if (tick)
        begin
            if (dem_t > dem_s + step) // R6
                dem_s <= dem_s + step;
            else if (dem_t < dem_s - step)
                dem_s <= dem_s - step;
            else
                dem_s <= dem_t;
            if (i_next > 28'sd1047552)
                integ <= 28'sd1047552; // anti-windup at full angle span
            else if (i_next < -28'sd1047552)
                integ <= -28'sd1047552;
            else
                integ <= i_next;
        end
    end

    // firing angle source selection
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            firing_angle_o <= 10'(`ANGLE_MIN);
        else if (ss_state != SS_RUN)
            firing_angle_o <= 10'(a_min); // R17
        else if (cfg.direct_en)
            firing_angle_o <= 10'(direct_angle); // R19
        else
            firing_angle_o <= 10'(loop_angle); // R5
    end

    // firing enable and ramp reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fire_enable_o <= 1'b0;
            ramp_reset_o  <= 1'b1;
        end
        else
        begin
            fire_enable_o <= !cfg.inhibit && ss_state != SS_OFF; // R16 R17
            ramp_reset_o  <= cfg.inhibit; // R16
        end
    end

    // bridge changes only at zero current and, with lockout set, never while the partner conducts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            bridge_sel_o <= 1'b0;
        else if (cur_abs == '0 && !(cfg.lockout && partner_s)) // R20
            bridge_sel_o <= dem_s < 0;
    end

    // standstill sequence
    wire ss_cause = cfg.ss_en && (stop_cmd_i || (!cfg.ss_mode && zero_ref_i)) // R18
                    && spd_abs < `STANDSTILL_SPD;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !ss_cause)
        begin
            ss_state <= SS_RUN;
            ss_cnt   <= '0;
        end
        else
        begin
            unique case (ss_state)
                SS_RUN:
                    ss_state <= SS_BACK; // R17
                SS_BACK:
                    if (tick)
                    begin
                        ss_cnt <= ss_cnt + 8'h01;
                        if (ss_cnt == `SS_DELAY_TICKS - 8'h01)
                            ss_state <= SS_OFF; // R17
                    end
                SS_OFF:
                    ss_state <= SS_OFF;
            endcase
        end
    end

    // taper flags, sampled once per tick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flag1 <= 1'b0;
            flag2 <= 1'b0;
        end
        else if (tick)
        begin
            flag1 <= spd_abs > thr1; // R2
            flag2 <= spd_abs > thr2; // R2
        end
    end

    // current-time overload; one tick per ms gives seconds per count
    wire [17:0] heat_lim = 18'(cfg.heat) * 18'(`TICKS_PER_SEC);
    wire [17:0] cool_lim = 18'(cfg.cool) * 18'(`TICKS_PER_SEC);
    wire [10:0] ovl_thr  = {1'b0, cfg.ovl_thr};
    wire [10:0] trip_pt  = `FULL_SCALE - ovl_thr; // R11
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc       <= '0;
            heat_frac <= '0;
            cool_frac <= '0;
        end
        else if (tick)
        begin
            if (cur_abs > ovl_thr) // R8
            begin
                cool_frac <= '0;
                if (heat_frac >= heat_lim) // R9
                begin
                    heat_frac <= '0;
                    if (acc < `ACC_MAX)
                        acc <= acc + 11'h001; // R11
                end
                else
                    heat_frac <= heat_frac + 18'(cur_abs - ovl_thr);
            end
            else if (cur_abs < ovl_thr)
            begin
                heat_frac <= '0;
                if (cool_frac >= cool_lim) // R9
                begin
                    cool_frac <= '0;
                    if (acc != '0)
                        acc <= acc - 11'h001;
                end
                else
                    cool_frac <= cool_frac + 18'(ovl_thr - cur_abs);
            end
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            overload_trip_o <= 1'b0;
        else
            overload_trip_o <= acc >= trip_pt; // R11
    end

    // autotune: run, then hold the ready relay open before clearing enable
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tune_state <= T_IDLE;
            relay_cnt  <= '0;
            tune_clear <= 1'b0;
        end
        else
        begin
            tune_clear <= 1'b0;
            unique case (tune_state)
                T_IDLE:
                    if (cfg.tune_en && start_i && !tune_clear) // no rerun while enable clears
                        tune_state <= T_RUN;
                T_RUN:
                    if (!cfg.tune_en)
                        tune_state <= T_IDLE;
                    else if (tune_done_i)
                    begin
                        tune_state <= T_OPEN;
                        relay_cnt  <= '0;
                    end
                T_OPEN:
                    if (relay_cnt == RELAY_CYCLES - 1) // R12
                    begin
                        tune_state <= T_IDLE;
                        tune_clear <= 1'b1;
                    end
                    else
                        relay_cnt <= relay_cnt + 32'h0000_0001;
            endcase
        end
    end
    assign ready_relay_o = tune_state != T_OPEN; // R12

    // register file; software writes come last so they win over hardware
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg             <= '0;
            cfg.t1_thr      <= `R_T_THR;
            cfg.t2_thr      <= `R_T_THR;
            cfg.slew        <= `R_SLEW;
            cfg.scaler      <= `R_SCALER;
            cfg.ovl_thr     <= `R_OVL_THR;
            cfg.heat        <= `R_HEAT;
            cfg.cool        <= `R_COOL;
            cfg.kid         <= `R_GAIN;
            cfg.kp          <= `R_GAIN;
            cfg.ki          <= `R_GAIN;
            cfg.motor_k     <= `R_MOTOR_K;
            cfg.ss_en       <= 1'b1;
        end
        else
        begin
            if (tune_clear)
                cfg.tune_en <= 1'b0; // R12
            if (tune_state == T_RUN && tune_done_i)
            begin
                cfg.kid     <= tune_result_i.kid;
                cfg.kp      <= tune_result_i.kp;
                cfg.ki      <= tune_result_i.ki;
                cfg.motor_k <= tune_result_i.motor_k; // R15
            end
            if (wr)
            begin
                case (adr_i)
                    `A_T1_SLOPE:  cfg.t1_slope    <= dat_i[7:0];
                    `A_T2_SLOPE:  cfg.t2_slope    <= dat_i[7:0];
                    `A_SLEW:      cfg.slew        <= dat_i[7:0];
                    `A_SCALER:    cfg.scaler      <= dat_i[10:0];
                    `A_OVL_THR:   cfg.ovl_thr     <= dat_i[9:0];
                    `A_HEAT:      cfg.heat        <= dat_i[7:0];
                    `A_COOL:      cfg.cool        <= dat_i[7:0];
                    `A_TUNE_EN:   cfg.tune_en     <= dat_i[0];
                    `A_ENDSTOP:   cfg.endstop_red <= dat_i[0];
                    `A_KID:       cfg.kid         <= dat_i[7:0];
                    `A_KP:        cfg.kp          <= dat_i[7:0];
                    `A_KI:        cfg.ki          <= dat_i[7:0];
                    `A_MOTOR_K:   cfg.motor_k     <= dat_i[7:0];
                    `A_INHIBIT:   cfg.inhibit     <= dat_i[0];
                    `A_SS_EN:     cfg.ss_en       <= dat_i[0];
                    `A_SS_MODE:   cfg.ss_mode     <= dat_i[0];
                    `A_DIRECT:    cfg.direct_en   <= dat_i[0];
                    `A_LOCKOUT:   cfg.lockout     <= dat_i[0];
                    `A_ADAPT_DIS: cfg.adapt_dis   <= dat_i[0];
                    `A_T1_THR:    cfg.t1_thr      <= dat_i[9:0];
                    `A_T2_THR:    cfg.t2_thr      <= dat_i[9:0];
                    default:      ;
                endcase
            end
        end
    end

    // displayed amps; scaling never reaches the control path
    wire signed [27:0] disp_full = (28'(current_fb_i) * $signed({17'h0, cfg.scaler}))
                                   / 28'sd1000;
    wire signed [15:0] disp = lim(disp_full, -`DISP_MAX, `DISP_MAX); // R4

    // read mux, unmapped and reserved words read zero
    always_comb
    begin
        rd_data = '0;
        case (adr_i)
            `A_T1_SLOPE:  rd_data[7:0]  = cfg.t1_slope;
            `A_T2_SLOPE:  rd_data[7:0]  = cfg.t2_slope;
            `A_T1_FLAG:   rd_data[0]    = flag1; // R2
            `A_T2_FLAG:   rd_data[0]    = flag2;
            `A_CUR_FB:    rd_data[15:0] = 16'(current_fb_i); // R3
            `A_DISP_AMPS: rd_data[15:0] = disp;
            `A_ANGLE:     rd_data[9:0]  = firing_angle_o;
            `A_SLEW:      rd_data[7:0]  = cfg.slew;
            `A_SCALER:    rd_data[10:0] = cfg.scaler;
            `A_OVL_THR:   rd_data[9:0]  = cfg.ovl_thr;
            `A_HEAT:      rd_data[7:0]  = cfg.heat;
            `A_COOL:      rd_data[7:0]  = cfg.cool;
            `A_TUNE_EN:   rd_data[0]    = cfg.tune_en;
            `A_ENDSTOP:   rd_data[0]    = cfg.endstop_red;
            `A_OVL_ACC:   rd_data[10:0] = acc; // R11
            `A_KID:       rd_data[7:0]  = cfg.kid;
            `A_KP:        rd_data[7:0]  = cfg.kp;
            `A_KI:        rd_data[7:0]  = cfg.ki;
            `A_MOTOR_K:   rd_data[7:0]  = cfg.motor_k;
            `A_INHIBIT:   rd_data[0]    = cfg.inhibit;
            `A_SS_EN:     rd_data[0]    = cfg.ss_en;
            `A_SS_MODE:   rd_data[0]    = cfg.ss_mode;
            `A_DIRECT:    rd_data[0]    = cfg.direct_en;
            `A_LOCKOUT:   rd_data[0]    = cfg.lockout;
            `A_ADAPT_DIS: rd_data[0]    = cfg.adapt_dis;
            `A_T1_THR:    rd_data[9:0]  = cfg.t1_thr;
            `A_T2_THR:    rd_data[9:0]  = cfg.t2_thr;
            default:      rd_data       = '0;
        endcase
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= '0;
        else if (cyc_i && stb_i && !ack_o)
            dat_o <= rd_data;
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack held beyond one cycle");
    a_angle_in_range: assert property (firing_angle_o >= 10'(`ANGLE_MIN)) // R5
        else $error("firing angle below endstop");
    a_inhibit_no_fire: assert property (cfg.inhibit |=> !fire_enable_o) // R16
        else $error("firing while inhibited");
    a_flag_follows: assert property (tick |=> flag1 == $past(spd_abs > thr1)) // R2
        else $error("taper flag wrong after tick");
    a_acc_bounded: assert property (acc <= `ACC_MAX) // R11
        else $error("overload accumulator out of range");
    a_trip_follows: assert property ((acc >= trip_pt) |=> overload_trip_o) // R11
        else $error("overload trip missed");
    a_lockout_hold: assert property ((cfg.lockout && partner_s) // R20
        |=> $stable(bridge_sel_o))
        else $error("bridge changed while partner conducts");
    a_direct_follow: assert property ((cfg.direct_en && ss_state == SS_RUN) // R19
        |=> firing_angle_o == 10'($past(direct_angle)))
        else $error("direct angle not followed");
    a_standstill_back: assert property ((ss_state == SS_BACK) // R17
        |=> firing_angle_o == 10'($past(a_min)))
        else $error("standstill did not phase back");
    a_tune_clears: assert property (tune_clear |-> ready_relay_o && !$past(ready_relay_o)) // R12
        else $error("relay open window wrong");
    c_tune_done: cover property (tune_clear);
    c_standstill_off: cover property (ss_state == SS_OFF);
    c_overload_trip: cover property ($rose(overload_trip_o));
    c_bridge_change: cover property ($changed(bridge_sel_o));
endmodule

// [rtl/current_loop_defs.svh]
// register offsets, reset values and timing counts of the current loop
`ifndef CURRENT_LOOP_DEFS_SVH
`define CURRENT_LOOP_DEFS_SVH
`define A_T1_SLOPE    8'h00
`define A_T2_SLOPE    8'h04
`define A_T1_FLAG     8'h08
`define A_T2_FLAG     8'h0C
`define A_CUR_FB      8'h10
`define A_DISP_AMPS   8'h14
`define A_ANGLE       8'h18
`define A_SLEW        8'h1C
`define A_SCALER      8'h20
`define A_OVL_THR     8'h24
`define A_HEAT        8'h28
`define A_COOL        8'h2C
`define A_TUNE_EN     8'h30
`define A_ENDSTOP     8'h34
`define A_OVL_ACC     8'h38
`define A_KID         8'h3C
`define A_KP          8'h40
`define A_KI          8'h44
`define A_MOTOR_K     8'h48
`define A_RSVD        8'h4C
`define A_INHIBIT     8'h50
`define A_SS_EN       8'h54
`define A_SS_MODE     8'h58
`define A_DIRECT      8'h5C
`define A_LOCKOUT     8'h60
`define A_ADAPT_DIS   8'h64
`define A_T1_THR      8'h68
`define A_T2_THR      8'h6C
`define R_T_THR       10'h3E8
`define R_OVL_THR     10'h2BC
`define R_HEAT        8'h1E
`define R_COOL        8'h32
`define R_GAIN        8'h10
`define R_MOTOR_K     8'h19
`define R_SLEW        8'h40
`define R_SCALER      11'h3E8
`define FULL_SCALE    11'h3E8
`define DISP_MAX      16'h07CF
`define ACC_MAX       11'h7CF
`define ANGLE_MIN     16'h0115
`define ANGLE_MIN_RED 16'h0149
`define ANGLE_MAX     16'h03FF
`define ANGLE_MID     16'h028A
`define STANDSTILL_SPD 11'h008
`define DISC_LEVEL    11'h032
`define SUPPLY_HZ     60
`define CLK_MHZ       100
`define TICK_US       1000
`define TICKS_PER_SEC 1000
`define RELAY_MS      50
`define TICK_CYCLES   (`TICK_US * `CLK_MHZ)
`define RELAY_CYCLES  (`RELAY_MS * 1000 * `CLK_MHZ)
`define SS_DELAY_TICKS 8'h64
`endif

// [rtl/current_loop_pkg.sv]
// types shared by the armature current loop
package current_loop_pkg;
    typedef struct packed {
        logic [9:0]  t1_thr;
        logic [9:0]  t2_thr;
        logic [7:0]  t1_slope;
        logic [7:0]  t2_slope;
        logic [7:0]  slew;
        logic [10:0] scaler;
        logic [9:0]  ovl_thr;
        logic [7:0]  heat;
        logic [7:0]  cool;
        logic        tune_en;
        logic        endstop_red;
        logic [7:0]  kid;
        logic [7:0]  kp;
        logic [7:0]  ki;
        logic [7:0]  motor_k;
        logic        inhibit;
        logic        ss_en;
        logic        ss_mode;
        logic        direct_en;
        logic        lockout;
        logic        adapt_dis;
    } cfg_type;
    typedef struct packed {
        logic [7:0] kid;
        logic [7:0] kp;
        logic [7:0] ki;
        logic [7:0] motor_k;
    } tune_result_type;
    typedef enum logic [2:0] {
        SS_RUN  = 3'b001,
        SS_BACK = 3'b010,
        SS_OFF  = 3'b100
    } ss_state_type;
    typedef enum logic [2:0] {
        T_IDLE = 3'b001,
        T_RUN  = 3'b010,
        T_OPEN = 3'b100
    } tune_state_type;
endpackage

// [verif/armature_current_loop_control_bench.sv]
// register-level bench of the armature current loop
`timescale 1ns/10ps
module armature_current_loop_control_bench;
    import current_loop_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic signed [11:0] speed_fb_i = 0, cur_fb, dem = 0, ref_v = 0;
    logic start_i = 0, done_i = 0, conducting, fire_en, ramp_rst, relay, bsel, trip;
    logic stop_i = 0, zref_i = 0;
    logic [9:0] angle;
    tune_result_type res_i = '0;
    int num_errors = 0, num_checks = 0, cycles = 0, n;
    localparam logic [7:0] RA[10] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C,
                                      8'h40, 8'h48, 8'h54, 8'h68, 8'h4C};
    localparam logic [15:0] RV[10] = '{16'h40, 16'h3E8, 16'h2BC, 16'h1E, 16'h32,
                                       16'h10, 16'h19, 16'h1, 16'h3E8, 16'h0};
    always #5 clk_i = ~clk_i;
    armature_current_loop_control #(.TICK_CYCLES(10), .RELAY_CYCLES(20)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .speed_fb_i(speed_fb_i), .current_fb_i(cur_fb), .current_demand_i(dem),
        .post_ramp_ref_i(ref_v), .stop_cmd_i(stop_i), .zero_ref_i(zref_i), .start_i(start_i),
        .tune_done_i(done_i), .tune_result_i(res_i), .partner_conducting_i(conducting),
        .firing_angle_o(angle), .fire_enable_o(fire_en), .bridge_sel_o(bsel),
        .ramp_reset_o(ramp_rst), .ready_relay_o(relay), .overload_trip_o(trip));
    firing_pulse_model u_far (.clk_i(clk_i), .firing_angle_i(angle), .fire_enable_i(fire_en),
        .bridge_sel_i(bsel), .current_fb_o(cur_fb), .conducting_o(conducting));
    task automatic results;
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // classic cycle held until ack, released right after it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 0; stb_i <= 0;
        @(posedge clk_i);
    endtask
    // hang guard well beyond the whole sequence
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            results;
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        for (int i = 0; i < 10; i++)
        begin
            bus(0, RA[i], 0);
            chk("reset value", q, {16'h0, RV[i]});
        end
        bus(1, 8'h00, 32'hA5); bus(0, 8'h00, 0); chk("slope", q, 32'hA5);
        bus(1, 8'h10, 32'h55); bus(0, 8'h10, 0); chk("feedback", q, 32'h64);
        bus(0, 8'h14, 0); chk("amps", q, 32'h64);
        chk("trip idle", trip, 0);
        bus(1, 8'h24, 32'h3E8);
        @(posedge clk_i);
        chk("trip at zero span", trip, 1);
        bus(1, 8'h24, 32'h2BC);
        bus(0, 8'h38, 0);
        chk("overload acc", q, 0);
        ref_v <= 12'sd500;
        bus(1, 8'h5C, 32'h1);
        bus(0, 8'h18, 0);
        chk("direct angle", q, 32'h1F4);
        ref_v <= 12'sd300;
        bus(1, 8'h34, 32'h1);
        bus(0, 8'h18, 0);
        chk("reduced endstop", q, 32'h149);
        bus(1, 8'h34, 32'h0);
        bus(0, 8'hF0, 0); chk("unmapped", q, 32'h0);
        speed_fb_i <= 12'sd500;
        bus(1, 8'h68, 32'h190);
        repeat (40) @(posedge clk_i);
        bus(0, 8'h08, 0); chk("flag one", q, 32'h1);
        bus(0, 8'h0C, 0); chk("flag two", q, 32'h0);
        bus(1, 8'h50, 32'h1);
        @(posedge clk_i);
        chk("fire enable", fire_en, 0);
        chk("ramp reset", ramp_rst, 1);
        bus(1, 8'h50, 32'h0);
        bus(1, 8'h30, 32'h1);
        start_i <= 1;
        @(posedge clk_i);
        res_i <= 32'h11223344; done_i <= 1;
        @(posedge clk_i);
        done_i <= 0;
        for (n = 0; n < 50 && relay !== 1'b0; n++) @(posedge clk_i);
        chk("relay open", relay, 0);
        for (n = 0; n < 100 && relay !== 1'b1; n++) @(posedge clk_i);
        chk("relay closed", relay, 1);
        chk("relay window", n, 20);
        repeat (2) @(posedge clk_i);
        start_i <= 0;
        bus(0, 8'h30, 0); chk("tune enable", q, 32'h0);
        bus(0, 8'h3C, 0); chk("tuned gain", q, 32'h11);
        bus(0, 8'h48, 0); chk("motor const", q, 32'h44);
        // standstill: zero reference first, then stop command only
        speed_fb_i <= 12'sd0;
        zref_i <= 1;
        repeat (3) @(posedge clk_i);
        bus(0, 8'h18, 0);
        chk("phase back", q, 32'h115);
        bus(1, 8'h58, 32'h1);
        repeat (1100) @(posedge clk_i);
        chk("zero ref only", fire_en, 1);
        stop_i <= 1;
        repeat (1100) @(posedge clk_i);
        chk("standstill off", fire_en, 0);
        results;
    end
endmodule

// [verif/firing_pulse_model.sv]
// behavioural firing pulse generator and bridges on the far side
`timescale 1ns/10ps
module firing_pulse_model (
    input  wire logic          clk_i,
    input  wire logic [9:0]    firing_angle_i,
    input  wire logic          fire_enable_i,
    input  wire logic          bridge_sel_i,
    output logic signed [11:0] current_fb_o,
    output logic               conducting_o
);
    // fixed conduction level; no current while firing is off
    always_ff @(posedge clk_i)
        current_fb_o <= !fire_enable_i ? 12'sh000 : (bridge_sel_i ? -12'sh064 : 12'sh064);
    assign conducting_o = fire_enable_i;
endmodule
